/* hw/nirr_pkg.sv */
// constants, types and timing for the nand rom reader host
package nirr_pkg;

    // ==========================================================
    // timing, printed figures in ns, cycle counts derived
    localparam int CLK_NS    = 5;
    localparam int T_WP_NS   = 25;
    localparam int T_WC_NS   = 50;
    localparam int T_REA_NS  = 35;
    localparam int T_RC_NS   = 50;
    localparam int T_WB_NS   = 200;
    localparam int T_RR_NS   = 20;
    localparam int T_CEH_NS  = 100;
    localparam int SYNC_CYC  = 2;

    function automatic int nirr_min_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WP_CYC  = nirr_min_cyc(T_WP_NS);
    localparam int WC_CYC  = nirr_min_cyc(T_WC_NS);
    localparam int REA_CYC = nirr_min_cyc(T_REA_NS);
    localparam int RC_CYC  = nirr_min_cyc(T_RC_NS);
    localparam int WB_CYC  = nirr_min_cyc(T_WB_NS);
    localparam int RR_CYC  = nirr_min_cyc(T_RR_NS);
    localparam int CEH_CYC = nirr_min_cyc(T_CEH_NS);
    localparam int TMR_W   = 8;

    // ==========================================================
    // commands and page geometry
    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h01;
    localparam logic [7:0] CMD_READ3 = 8'h50;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] SPARE_VAL = 8'hFF;

    localparam int         COL_W      = 10;
    localparam int         PG_W       = 5;
    localparam logic [9:0] PAGE_MAIN  = 10'h200;
    localparam logic [9:0] PAGE_LAST  = 10'h20F;
    localparam logic [4:0] PG_LAST    = 5'h1F;
    localparam int         ADDR_BYTES = 3;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        NIRR_RD1 = 2'h0,
        NIRR_RD2 = 2'h1,
        NIRR_RD3 = 2'h2,
        NIRR_RST = 2'h3
    } nirr_op_t;

    typedef struct packed {
        nirr_op_t    op;
        logic [24:0] addr;
    } nirr_req_t;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic output_strobe_n;
    } nirr_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD  = 3'h1,
        ST_ADDR = 3'h3,
        ST_BUSY = 3'h2,
        ST_READ = 3'h6,
        ST_END  = 3'h7
    } nirr_state_t;

endpackage

/* hw/nirr_host.sv */
// host controller driving a nand-style read-only memory over its pins
// How it works
// - host sends only reset while busy
// - one shared 8-bit bidirectional bus
// - latch, select and strobe levels per cycle
// - three address bytes, low byte first
// - no strobe until ready after page end
`timescale 1ns/1ps
module nirr_host
    import nirr_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 req_valid_i,
    input  wire nirr_pkg::nirr_req_t  req_i,
    output logic                      req_ready_o,
    input  wire logic                 stop_i,
    output logic [7:0]                rd_data_o,
    output logic                      rd_valid_o,
    output logic                      spare_err_o,
    output logic                      done_o,
    output nirr_pkg::nirr_pins_t      pins_o,
    output logic [7:0]                io_out_o,
    output logic                      io_oe_o,
    input  wire logic [7:0]           io_in_i,
    input  wire logic                 ready_busy_n_i
);
    import nirr_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [7:0] cmd_byte(input nirr_op_t op);
        case (op)
            NIRR_RD1: return CMD_READ1;
            NIRR_RD2: return CMD_READ2;
            NIRR_RD3: return CMD_READ3;
            default:  return CMD_RESET;
        endcase
    endfunction

    // a8 never goes on the bus; upper nibble zero in mode three
    function automatic logic [7:0] addr_byte(input nirr_op_t op,
                                             input logic [24:0] a,
                                             input logic [1:0] sel);
        case (sel)
            2'h0:    return (op == NIRR_RD3) ? {4'h0, a[3:0]} : a[7:0];
            2'h1:    return a[16:9];
            default: return a[24:17];
        endcase
    endfunction

    // first column of the area that the read mode selects
    function automatic logic [9:0] first_col(input nirr_op_t op,
                                             input logic [7:0] lo);
        case (op)
            NIRR_RD2: return {2'h1, lo};
            NIRR_RD3: return PAGE_MAIN | {6'h00, lo[3:0]};
            default:  return {2'h0, lo};
        endcase
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic       rdy_meta;
    logic       rdy_sync;

    always_ff @(posedge clk_i) begin
        io_meta <= io_in_i;
        io_sync <= io_meta;
        rdy_meta <= ready_busy_n_i;
        rdy_sync <= rdy_meta;
    end

    // ==========================================================
    // sequencer and pins
    nirr_state_t      state;
    nirr_op_t         op;
    logic [24:0]      addr;
    logic [1:0]       byte_sel;
    logic [TMR_W-1:0] tmr;
    logic [COL_W-1:0] col;
    logic [PG_W-1:0]  page;

    always_ff @(posedge clk_i) begin
        rd_valid_o <= 1'b0;
        done_o     <= 1'b0;
        if (reset_i) begin
            state       <= ST_IDLE;
            op          <= NIRR_RD1;
            addr        <= '0;
            byte_sel    <= 2'h0;
            tmr         <= '0;
            col         <= '0;
            page        <= '0;
            pins_o      <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
                             we_n: 1'b1, output_strobe_n: 1'b1};
            io_out_o    <= 8'h00;
            io_oe_o     <= 1'b0;
            req_ready_o <= 1'b0;
            rd_data_o   <= 8'h00;
            spare_err_o <= 1'b0;
        end else begin
            case (state)
            ST_IDLE: begin
                // reads wait for ready; reset may go at any time
                req_ready_o <= rdy_sync;
                if (req_valid_i && (req_i.op == NIRR_RST || rdy_sync)) begin
                    op          <= req_i.op;
                    addr        <= req_i.addr;
                    col         <= first_col(req_i.op,
                                             req_i.addr[7:0]);
                    page        <= req_i.addr[13:9];
                    byte_sel    <= 2'h0;
                    tmr         <= '0;
                    io_out_o    <= cmd_byte(req_i.op);
                    io_oe_o     <= 1'b1;
                    pins_o      <= '{cle: 1'b1, ale: 1'b0, ce_n: 1'b0,
                                     we_n: 1'b0,
                                     output_strobe_n: 1'b1};
                    req_ready_o <= 1'b0;
                    spare_err_o <= 1'b0;
                    state       <= ST_CMD;
                end
            end
            ST_CMD, ST_ADDR: begin
                tmr <= tmr + 1'b1;
                if (tmr == TMR_W'(WP_CYC - 1))
                    pins_o.we_n <= 1'b1;
                if (tmr == TMR_W'(WC_CYC - 1)) begin
                    tmr <= '0;
                    if (op == NIRR_RST || byte_sel == 2'(ADDR_BYTES)) begin
                        io_oe_o    <= 1'b0;
                        pins_o.cle <= 1'b0;
                        pins_o.ale <= 1'b0;
                        state      <= ST_BUSY;
                    end else begin
                        // a8 set by command, never on the bus
                        io_out_o    <= addr_byte(op, addr,
                                                 byte_sel);
                        byte_sel    <= byte_sel + 1'b1;
                        pins_o.cle  <= 1'b0;
                        pins_o.ale  <= 1'b1;
                        pins_o.we_n <= 1'b0;
                        state       <= ST_ADDR;
                    end
                end
            end
            ST_BUSY: begin
                // blind wait covers the gap before busy shows
                if (tmr < TMR_W'(WB_CYC))
                    tmr <= tmr + 1'b1;
                else if (!rdy_sync)
                    tmr <= tmr;
                else if (tmr < TMR_W'(WB_CYC + RR_CYC))
                    tmr <= tmr + 1'b1;
                else begin
                    tmr <= '0;
                    if (op == NIRR_RST) begin
                        pins_o.ce_n <= 1'b1;
                        state       <= ST_END;
                    end else begin
                        pins_o.output_strobe_n <= 1'b0;
                        state       <= ST_READ;
                    end
                end
            end
            ST_READ: begin
                tmr <= tmr + 1'b1;
                if (tmr == TMR_W'(REA_CYC + SYNC_CYC - 1)) begin
                    rd_data_o   <= io_sync;
                    rd_valid_o  <= 1'b1;
                    pins_o.output_strobe_n <= 1'b1;
                    if (col >= PAGE_MAIN && io_sync != SPARE_VAL)
                        spare_err_o <= 1'b1;
                end
                if (tmr == TMR_W'(RC_CYC - 1)) begin
                    tmr <= '0;
                    if (col == PAGE_LAST) begin
                        col <= (op == NIRR_RD3) ? PAGE_MAIN : '0;
                        if (page == PG_LAST) begin
                            pins_o.ce_n <= 1'b1;
                            state       <= ST_END;
                        end else begin
                            page  <= page + 1'b1;
                            state <= ST_BUSY;
                        end
                    end else begin
                        col <= col + 1'b1;
                        if (stop_i) begin
                            pins_o.ce_n <= 1'b1;
                            state       <= ST_END;
                        end else
                            pins_o.output_strobe_n <= 1'b0;
                    end
                end
            end
            ST_END: begin
                tmr <= tmr + 1'b1;
                if (tmr == TMR_W'(CEH_CYC - 1)) begin
                    tmr    <= '0;
                    done_o <= 1'b1;
                    state  <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_cmd_levels: assert property ($fell(pins_o.we_n) |->
        !pins_o.ce_n && pins_o.output_strobe_n &&
        (pins_o.cle ^ pins_o.ale))
        else $error("bad latch levels at write strobe");
    a_we_width: assert property ($fell(pins_o.we_n) |->
        !pins_o.we_n [*5] ##1 pins_o.we_n)
        else $error("write strobe width wrong");
    a_bus_turn: assert property (!pins_o.output_strobe_n |->
        !io_oe_o)
        else $error("host drives bus during read strobe");
    a_cmd_busy: assert property ($fell(pins_o.we_n) &&
        pins_o.cle |-> io_out_o == CMD_RESET || rdy_sync)
        else $error("non-reset command while busy");
    a_cmd_code: assert property (state == ST_CMD &&
        $fell(pins_o.we_n) |-> io_out_o == cmd_byte(op))
        else $error("wrong command code");
    a_addr_hi: assert property (byte_sel == 2'h3 &&
        $fell(pins_o.we_n) |-> io_out_o == addr[24:17])
        else $error("third address byte wrong");
    a_nib_mode3: assert property (byte_sel == 2'h1 &&
        $fell(pins_o.we_n) && op == NIRR_RD3 |-> io_out_o[7:4] == 4'h0)
        else $error("upper nibble not zero in mode three");
    a_strb_rdy: assert property ($fell(pins_o.output_strobe_n) |->
        rdy_sync)
        else $error("read strobe while busy");
    a_block_end: assert property (rd_valid_o &&
        col == PAGE_LAST && page == PG_LAST |-> ##2 state == ST_END &&
        pins_o.ce_n)
        else $error("read did not stop at block end");

    c_read: cover property (rd_valid_o ##[1:20] rd_valid_o);
    c_page: cover property (state == ST_READ ##1 state == ST_BUSY);
    c_reset: cover property (state == ST_CMD && op == NIRR_RST);
    c_mode3: cover property (rd_valid_o && op == NIRR_RD3);

endmodule

/* dv/nirr_dev_model.sv */
// behavioural model of the nand-style read-only memory
`timescale 1ns/1ps
module nirr_dev_model
    import nirr_pkg::*;
#(
    parameter int LOAD_CYC = 1200
)(
    input  wire logic                 clk_i,
    input  wire nirr_pkg::nirr_pins_t pins_i,
    input  wire logic [7:0]           bus_i,
    input  wire logic                 host_oe_i,
    input  wire logic                 bad_spare_i,
    output logic [7:0]                bus_o,
    output logic                      ready_busy_n_o,
    output logic [7:0]                cmd_o,
    output logic [15:0]               row_o,
    output logic [7:0]                viol_o
);
    import nirr_pkg::*;
    // ==========================================================
    // state
    logic [9:0]  col = 10'h000;
    logic [1:0]  nadr = 2'h3;
    logic [10:0] busy_cnt = 11'h000;
    logic        drive = 1'b0;
    logic        ended = 1'b1;
    logic [7:0]  last = 8'h00;
    initial cmd_o = 8'h00;
    initial row_o = 16'h0000;
    initial viol_o = 8'h00;
    // no pull on the data lines: released bus shows the inverse
    assign bus_o = drive ? last : ~last;
    assign ready_busy_n_o = (busy_cnt == 11'h000);
    always @(posedge clk_i) begin
        if (busy_cnt != 11'h000) busy_cnt = busy_cnt - 11'h001;
    end
    // ==========================================================
    // command and address latching
    always @(posedge pins_i.we_n) begin
        if (pins_i.ce_n === 1'b0) begin
            if (!pins_i.output_strobe_n || !host_oe_i
                || pins_i.cle == pins_i.ale)
                viol_o = viol_o + 8'h01;
            if (busy_cnt != 0 && !(pins_i.cle && bus_i == CMD_RESET))
                viol_o = viol_o + 8'h01;
            if (pins_i.cle) begin
                cmd_o = bus_i;
                nadr = 2'h0;
                ended = 1'b1;
                if (bus_i == CMD_RESET) busy_cnt = 11'(LOAD_CYC / 4);
            end else if (nadr != 2'h3) begin
                case (nadr)
                    2'h0: col = (cmd_o == CMD_READ3)
                        ? {6'h20, bus_i[3:0]}
                        : {1'b0, cmd_o == CMD_READ2,
                           bus_i};
                    2'h1: row_o[7:0] = bus_i;
                    default: begin
                        row_o[15:8] = bus_i;
                        busy_cnt = 11'(LOAD_CYC);
                        ended = 1'b0;
                    end
                endcase
                nadr = nadr + 2'h1;
            end
        end
    end
    // ==========================================================
    // serial read
    always @(negedge pins_i.output_strobe_n) begin
        if (pins_i.ce_n === 1'b0) begin
            if (busy_cnt != 0 || ended || pins_i.cle || pins_i.ale
                || !pins_i.we_n)
                viol_o = viol_o + 8'h01;
            #20;
            last = (col >= PAGE_MAIN)
                ? (bad_spare_i ? 8'h00 : SPARE_VAL)
                : col[7:0] ^ row_o[7:0] ^ {col[8], 7'h00};
            drive = !pins_i.output_strobe_n && !pins_i.ce_n;
        end
    end
    always @(posedge pins_i.output_strobe_n) begin
        drive = 1'b0;
        if (pins_i.ce_n === 1'b0 && !ended) begin
            if (col == PAGE_LAST) begin
                col = (cmd_o == CMD_READ3) ? PAGE_MAIN : 10'h000;
                if (row_o[4:0] == PG_LAST) ended = 1'b1;
                else begin
                    row_o = row_o + 16'h0001;
                    busy_cnt = 11'(LOAD_CYC);
                end
            end else col = col + 10'h001;
        end
    end
    always @(posedge pins_i.ce_n) drive = 1'b0;
endmodule

/* dv/tb_top.sv */
// self-checking bench for the nand rom reader host
`timescale 1ns/1ps
module tb_top;
    import nirr_pkg::*;
    // ==========================================================
    // signals and instances
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       req_valid_i = 1'b0;
    nirr_req_t  req_i = '0;
    logic       stop_i = 1'b0;
    logic       bad_spare = 1'b0;
    logic       req_ready_o, rd_valid_o, spare_err_o, done_o, io_oe_o;
    logic       ready_busy_n;
    logic [7:0] rd_data_o, io_out_o, dev_bus, cmd, viol;
    logic [15:0] row;
    nirr_pins_t pins_o;
    wire [7:0]  io_in = io_oe_o ? io_out_o : dev_bus;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         got;
    always #2.5 clk_i = ~clk_i;
    nirr_host u_nirr_host (.clk_i(clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .stop_i(stop_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .spare_err_o(spare_err_o), .done_o(done_o), .pins_o(pins_o),
        .io_out_o(io_out_o), .io_oe_o(io_oe_o), .io_in_i(io_in),
        .ready_busy_n_i(ready_busy_n));
    nirr_dev_model u_nirr_dev_model (.clk_i(clk_i), .pins_i(pins_o),
        .bus_i(io_out_o), .host_oe_i(io_oe_o), .bad_spare_i(bad_spare),
        .bus_o(dev_bus), .ready_busy_n_o(ready_busy_n), .cmd_o(cmd),
        .row_o(row),
        .viol_o(viol));
    // ==========================================================
    // shared tasks
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // whole run is about 10k cycles; the ceiling leaves ample margin
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [9:0] c,
                                            input logic [15:0] r);
        if (c >= PAGE_MAIN) return bad_spare ? 8'h00 : SPARE_VAL;
        return c[7:0] ^ r[7:0] ^ {c[8], 7'h00};
    endfunction
    task automatic run_op(input nirr_op_t op, input logic [24:0] a,
                          input int nstop, output int n);
        logic [9:0]  c;
        logic [15:0] r;
        logic [7:0]  e;
        c = (op == NIRR_RD3) ? {6'h20, a[3:0]}
            : {1'b0, op == NIRR_RD2, a[7:0]};
        r = a[24:9];
        n = 0;
        while (req_ready_o !== 1'b1) @(negedge clk_i);
        req_i = '{op: op, addr: a};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1) begin
            @(negedge clk_i);
            if (rd_valid_o === 1'b1) begin
                e = exp_byte(c, r);
                chk(rd_data_o, e);
                n = n + 1;
                if (c == PAGE_LAST) begin
                    c = (op == NIRR_RD3) ? PAGE_MAIN : 10'h000;
                    r = r + 16'h0001;
                end else c = c + 10'h001;
                if (n == nstop) stop_i = 1'b1;
            end
        end
        stop_i = 1'b0;
        chk({pins_o.ce_n, io_oe_o}, 2'b10);
        // device is ready again, so idle offers the next request
        @(negedge clk_i);
        chk(req_ready_o, 1'b1);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        run_op(NIRR_RST, 25'h0, 0, got);
        chk(cmd, CMD_RESET);
        chk(got, 0);
        $display("test reset done");
    endtask
    task automatic t_mode1();
        run_op(NIRR_RD1, {16'hA5C3, 1'b1, 8'hFE}, 4, got);
        chk(cmd, CMD_READ1);
        chk(row, 16'hA5C3);
        chk(got, 4);
        $display("test mode one done");
    endtask
    task automatic t_mode2();
        run_op(NIRR_RD2, {16'h0102, 1'b0, 8'hFA}, 26, got);
        chk(cmd, CMD_READ2);
        chk(row, 16'h0103);
        chk(got, 26);
        chk(spare_err_o, 1'b0);
        $display("test mode two done");
    endtask
    task automatic t_mode3();
        run_op(NIRR_RD3, {16'h0040, 1'b0, 8'hF3}, 16, got);
        chk(cmd, CMD_READ3);
        chk(row, 16'h0041);
        chk(got, 16);
        chk(spare_err_o, 1'b0);
        $display("test mode three done");
    endtask
    task automatic t_block_end();
        run_op(NIRR_RD3, {16'h005F, 1'b0, 8'h0E}, 100, got);
        chk(got, 2);
        $display("test block end done");
    endtask
    task automatic t_bad_spare();
        bad_spare = 1'b1;
        run_op(NIRR_RD2, {16'h0007, 1'b0, 8'hFF}, 3, got);
        chk(spare_err_o, 1'b1);
        bad_spare = 1'b0;
        $display("test bad spare done");
    endtask
    initial begin
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        t_reset();
        t_mode1();
        t_mode2();
        t_mode3();
        t_block_end();
        t_bad_spare();
        chk(viol, 8'h00);
        end_sim();
    end
endmodule
